// ### hdl/manchester_codec_mode_pkg.sv
// Constants shared by the codec mode pin multiplexer
package manchester_codec_mode_pkg;
  localparam logic MODE_EXTERNAL = 1'b0;
  localparam logic STRAP_RESET = 1'b1;
  localparam logic LED_OFF = 1'b1;
  localparam logic TXEN_IDLE_N = 1'b1;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic [1:0] SYNC_RESET_HI = 2'h3;
  localparam logic [1:0] STRAP_COUNT_RESET = 2'h0;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
  typedef enum logic [1:0] {
    MODE_INT = 2'b01,
    MODE_EXT = 2'b10
  } codec_mode_t;
endpackage

// ### hdl/manchester_codec_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module manchester_codec_sync2
  import manchester_codec_mode_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic stage1;
  logic next_stage1;
  logic next_q;

  always_comb
  begin
    next_stage1 = d;
    next_q = stage1;
    if (rst)
    begin
      next_stage1 = RESET_VALUE;
      next_q = RESET_VALUE;
    end
  end

  always_ff @(posedge clk)
  begin
    stage1 <= next_stage1;
    q <= next_q;
  end
endmodule
`default_nettype wire

// ### hdl/manchester_codec_mode_pin_mux.sv
// Pin role multiplexer between internal and external Manchester codec paths
`timescale 1ns/100ps
`default_nettype none
module manchester_codec_mode_pin_mux
  import manchester_codec_mode_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic EXTERNAL_CODEC_SELECT_N,
  // Shared pad: receive LED out (internal) or receive clock in (external)
  input wire logic RX_LED_PAD_IN,
  output logic RECEIVE_ACTIVITY_LED_N,
  output logic RX_LED_PAD_OE_N,
  // Receive clock domain logic is clocked from this dedicated port, not the pad's input
  input wire logic EXT_RECEIVE_CLOCK,
  input wire logic EXT_TRANSMIT_CLOCK,
  input wire logic EXT_RECEIVE_NRZ,
  input wire logic COLLISION_IN_N,
  input wire logic CARRIER_SENSE_IN_N,
  output logic TX_DIFF_OE_N,
  output logic LINK_LED_N,
  output logic TRANSMIT_ACTIVITY_LED_N,
  // Core side
  input wire logic CORE_RX_ACTIVE,
  input wire logic CORE_TX_ACTIVE,
  input wire logic CORE_LINK_UP,
  input wire logic CORE_TX_DATA,
  input wire logic CORE_TX_FRAME,
  output logic CORE_EXTERNAL_MODE,
  output logic CORE_RX_DATA,
  output logic CORE_COLLISION,
  output logic CORE_CARRIER
);
  codec_mode_t mode;
  codec_mode_t next_mode;
  logic strap_sync;
  logic strap_seen;
  logic next_strap_seen;
  logic [1:0] strap_count;
  logic [1:0] next_strap_count;
  logic rx_led_n;
  logic next_rx_led_n;
  logic link_led;
  logic next_link_led;
  logic tx_led;
  logic next_tx_led;
  logic rx_pad_oe_n;
  logic next_rx_pad_oe_n;
  logic diff_oe_n;
  logic next_diff_oe_n;
  logic ext_mode_flag;
  logic next_ext_mode_flag;
  logic rx_data_sync;
  logic coll_sync;
  logic crs_sync;
  logic tx_frame_sync;
  logic tx_data_sync;
  logic ext_sync_tx;
  logic ext_receive_clock_sample;
  logic rx_core;
  logic next_rx_core;
  logic coll_core;
  logic next_coll_core;
  logic crs_core;
  logic next_crs_core;
  // Receive clock domain
  logic rx_nrz_cap;
  // Transmit clock domain
  logic txd_launch;
  logic next_txd_launch;
  logic txen_launch_n;
  logic next_txen_launch_n;

  // Strap is caught after reset release, so reset itself only loads a constant
  manchester_codec_sync2 #(.RESET_VALUE(STRAP_RESET)) u_strap (
    .clk(CLK), .rst(SRST), .d(EXTERNAL_CODEC_SELECT_N), .q(strap_sync)
  );

  always_comb
  begin
    next_mode = mode;
    next_strap_seen = strap_seen;
    next_strap_count = strap_count;
    // The synchroniser still shows its reset value for two edges; latching earlier would lose the strap
    if (strap_count != STRAP_SETTLE_CYCLES)
    begin
      next_strap_count = strap_count + 2'h1;
    end
    else if (!strap_seen)
    begin
      next_strap_seen = 1'b1;
      next_mode = (strap_sync == MODE_EXTERNAL) ? MODE_EXT : MODE_INT;
    end
    if (SRST)
    begin
      next_mode = MODE_INT;
      next_strap_seen = 1'b0;
      next_strap_count = STRAP_COUNT_RESET;
    end
  end

  always_ff @(posedge CLK)
  begin
    mode <= next_mode;
    strap_seen <= next_strap_seen;
    strap_count <= next_strap_count;
  end

  // Receive data sampled on the external receive clock
  always_ff @(posedge EXT_RECEIVE_CLOCK)
  begin
    rx_nrz_cap <= EXT_RECEIVE_NRZ;
  end

  // Mode level into the transmit clock domain
  manchester_codec_sync2 #(.RESET_VALUE(1'b0)) u_mode_tx (
    .clk(EXT_TRANSMIT_CLOCK), .rst(1'b0), .d(ext_mode_flag), .q(ext_sync_tx)
  );
  manchester_codec_sync2 #(.RESET_VALUE(1'b0)) u_frame_tx (
    .clk(EXT_TRANSMIT_CLOCK), .rst(1'b0), .d(CORE_TX_FRAME), .q(tx_frame_sync)
  );
  manchester_codec_sync2 #(.RESET_VALUE(1'b0)) u_data_tx (
    .clk(EXT_TRANSMIT_CLOCK), .rst(1'b0), .d(CORE_TX_DATA), .q(tx_data_sync)
  );

  always_comb
  begin
    next_txd_launch = 1'b0;
    next_txen_launch_n = TXEN_IDLE_N;
    if (ext_sync_tx)
    begin
      next_txd_launch = tx_data_sync;
      next_txen_launch_n = ~tx_frame_sync;
    end
  end

  always_ff @(posedge EXT_TRANSMIT_CLOCK)
  begin
    txd_launch <= next_txd_launch;
    txen_launch_n <= next_txen_launch_n;
  end

  // Captured receive bit and pad pins brought into the core clock
  manchester_codec_sync2 #(.RESET_VALUE(1'b0)) u_rxd (
    .clk(CLK), .rst(SRST), .d(rx_nrz_cap), .q(rx_data_sync)
  );
  manchester_codec_sync2 #(.RESET_VALUE(1'b1)) u_coll (
    .clk(CLK), .rst(SRST), .d(COLLISION_IN_N), .q(coll_sync)
  );
  manchester_codec_sync2 #(.RESET_VALUE(1'b1)) u_crs (
    .clk(CLK), .rst(SRST), .d(CARRIER_SENSE_IN_N), .q(crs_sync)
  );
  // Pad level is read back to confirm the open-drain LED pulls it; clocking uses the dedicated port
  manchester_codec_sync2 #(.RESET_VALUE(1'b1)) u_rxpad (
    .clk(CLK), .rst(SRST), .d(RX_LED_PAD_IN), .q(ext_receive_clock_sample)
  );

  always_comb
  begin
    next_rx_core = 1'b0;
    next_coll_core = 1'b0;
    next_crs_core = 1'b0;
    next_rx_led_n = LED_OFF;
    next_link_led = LED_OFF;
    next_tx_led = LED_OFF;
    next_rx_pad_oe_n = 1'b0;
    next_diff_oe_n = 1'b0;
    next_ext_mode_flag = 1'b0;
    unique case (mode)
      MODE_INT:
      begin
        // Receive-data pin is left unread here; stale NRZ cannot leak into the core
        next_rx_core = 1'b0;
        next_rx_led_n = ~CORE_RX_ACTIVE;
        next_rx_pad_oe_n = ~CORE_RX_ACTIVE;
        next_link_led = ~CORE_LINK_UP;
        next_tx_led = ~CORE_TX_ACTIVE;
        next_diff_oe_n = 1'b0;
      end
      MODE_EXT:
      begin
        next_ext_mode_flag = 1'b1;
        next_rx_core = rx_data_sync;
        next_rx_pad_oe_n = 1'b1;
        next_diff_oe_n = 1'b1;
        next_coll_core = ~coll_sync;
        next_crs_core = ~crs_sync;
      end
    endcase
    if (SRST)
    begin
      next_rx_core = 1'b0;
      next_coll_core = 1'b0;
      next_crs_core = 1'b0;
      next_rx_led_n = LED_OFF;
      next_link_led = LED_OFF;
      next_tx_led = LED_OFF;
      next_rx_pad_oe_n = 1'b1;
      next_diff_oe_n = 1'b1;
      next_ext_mode_flag = 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    rx_core <= next_rx_core;
    coll_core <= next_coll_core;
    crs_core <= next_crs_core;
    rx_led_n <= next_rx_led_n;
    link_led <= next_link_led;
    tx_led <= next_tx_led;
    rx_pad_oe_n <= next_rx_pad_oe_n;
    diff_oe_n <= next_diff_oe_n;
    ext_mode_flag <= next_ext_mode_flag;
  end

  // Open-drain LED: pad level only ever pulled low, enable drops while driving
  assign RECEIVE_ACTIVITY_LED_N = rx_led_n;
  assign RX_LED_PAD_OE_N = rx_pad_oe_n;
  assign TX_DIFF_OE_N = diff_oe_n;
  // Shared pins take the transmit-clock flops in external mode; mode is static after reset
  assign LINK_LED_N = ext_mode_flag ? txd_launch : link_led;
  assign TRANSMIT_ACTIVITY_LED_N = ext_mode_flag ? txen_launch_n : tx_led;
  assign CORE_EXTERNAL_MODE = ext_mode_flag;
  assign CORE_RX_DATA = rx_core;
  assign CORE_COLLISION = coll_core;
  assign CORE_CARRIER = crs_core;

  a_strap_mode: assert property (@(posedge CLK) disable iff (SRST)
    $rose(strap_seen) |-> (ext_mode_flag == 1'b0) ##1 (ext_mode_flag == (mode == MODE_EXT)))
    else $error("mode flag does not follow strap");
  a_mode_static: assert property (@(posedge CLK) disable iff (SRST)
    strap_seen && $past(strap_seen) |-> $stable(mode))
    else $error("mode changed after reset");
  a_int_rx_ignored: assert property (@(posedge CLK) disable iff (SRST)
    (mode == MODE_INT) && $past(mode == MODE_INT) |-> rx_core == 1'b0)
    else $error("receive data passed in internal mode");
  a_ext_rx_path: assert property (@(posedge CLK) disable iff (SRST)
    (mode == MODE_EXT) && $past(mode == MODE_EXT) |=> rx_core == $past(rx_data_sync))
    else $error("receive data not passed in external mode");
  a_rx_pad_input: assert property (@(posedge CLK) disable iff (SRST)
    ext_mode_flag |-> RX_LED_PAD_OE_N)
    else $error("receive clock pad driven in external mode");
  a_int_rx_led: assert property (@(posedge CLK) disable iff (SRST)
    !$past(SRST) && (mode == MODE_INT) && $past(mode == MODE_INT) && $past(CORE_RX_ACTIVE) |-> !RX_LED_PAD_OE_N)
    else $error("receive LED not driven low");
  a_led_readback: assert property (@(posedge CLK) disable iff (SRST)
    !$past(SRST) && !$past(SRST, 2) && !$past(rx_pad_oe_n, 2) |-> !ext_receive_clock_sample)
    else $error("receive LED pad not pulled low");
  a_ext_collision: assert property (@(posedge CLK) disable iff (SRST)
    (mode == MODE_EXT) && $past(mode == MODE_EXT) |=> coll_core == !$past(coll_sync) && TX_DIFF_OE_N)
    else $error("collision input not passed");
  a_int_link_led: assert property (@(posedge CLK) disable iff (SRST)
    (mode == MODE_INT) && $past(mode == MODE_INT) && !ext_mode_flag |=> LINK_LED_N == !$past(CORE_LINK_UP))
    else $error("link LED wrong");
  a_int_tx_led: assert property (@(posedge CLK) disable iff (SRST)
    (mode == MODE_INT) && $past(mode == MODE_INT) && !ext_mode_flag |=> TRANSMIT_ACTIVITY_LED_N == !$past(CORE_TX_ACTIVE))
    else $error("transmit LED wrong");
  a_tx_idle: assert property (@(posedge EXT_TRANSMIT_CLOCK)
    !ext_sync_tx |=> txen_launch_n && !txd_launch)
    else $error("transmit enable active outside external mode");
endmodule
`default_nettype wire

// ### dv/manchester_codec_ext_codec_model.sv
// Behavioural outside codec driving the external codec path
`timescale 1ns/100ps
`default_nettype none
module manchester_codec_ext_codec_model
(
  input wire logic rx_run,
  input wire logic tx_run,
  input wire logic rx_bit,
  output logic rx_clock,
  output logic tx_clock,
  output logic nrz
);
  logic nrz_q;
  initial
  begin
    // One rising edge at start loads the far-side flops from the idle line
    rx_clock = 1'h0;
    tx_clock = 1'h0;
    nrz_q = 1'h1;
  end
  // Clocks stand high between frames, where only the pull-up holds the line
  always
  begin
    #16;
    rx_clock = rx_run ? ~rx_clock : 1'h1;
  end
  // Offset start keeps transmit and receive clocks out of phase
  always
  begin
    #5;
    forever
    begin
      #16;
      tx_clock = tx_run ? ~tx_clock : 1'h1;
    end
  end
  always @(negedge rx_clock) nrz_q <= rx_bit;
  // A released data line floats to its pull-up
  assign nrz = rx_run ? nrz_q : 1'h1;
endmodule
`default_nettype wire

// ### dv/manchester_codec_mode_pin_mux_tb.sv
// Self-checking bench for the codec mode pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module manchester_codec_mode_pin_mux_tb;
  import manchester_codec_mode_pkg::*;
  typedef struct packed {logic strap; logic [2:0] core; logic [1:0] cs; logic [4:0] em; logic [2:0] el;} row_t;
  logic CLK, SRST, strap, rx_act, tx_act, link, coll_n, crs_n, tx_data, tx_frame, rx_run, tx_run, rx_bit;
  wire logic rx_clock, tx_clock, nrz, pad_oe_n, ext_mode, rx_data, coll, crs, rx_led_n, diff_oe_n, link_n, tx_led_n;
  wire logic pad = pad_oe_n ? rx_clock : 1'h0;
  int fails, tests_run;
  row_t rows [7] = '{'{1'h1, 3'h0, 2'h0, 5'h08, 3'h7}, '{1'h1, 3'h5, 2'h0, 5'h00, 3'h1},
    '{1'h1, 3'h2, 2'h1, 5'h08, 3'h6}, '{1'h0, 3'h7, 2'h0, 5'h1F, 3'h0}, '{1'h0, 3'h7, 2'h1, 5'h1E, 3'h0},
    '{1'h0, 3'h0, 2'h2, 5'h1D, 3'h0}, '{1'h0, 3'h0, 2'h3, 5'h1C, 3'h0}};
  manchester_codec_ext_codec_model i_model (.rx_run(rx_run), .tx_run(tx_run), .rx_bit(rx_bit), .rx_clock(rx_clock),
    .tx_clock(tx_clock), .nrz(nrz));
  manchester_codec_mode_pin_mux i_dut (.CLK(CLK), .SRST(SRST), .EXTERNAL_CODEC_SELECT_N(strap), .RX_LED_PAD_IN(pad),
    .RECEIVE_ACTIVITY_LED_N(rx_led_n), .RX_LED_PAD_OE_N(pad_oe_n), .EXT_RECEIVE_CLOCK(rx_clock),
    .EXT_TRANSMIT_CLOCK(tx_clock), .EXT_RECEIVE_NRZ(nrz), .COLLISION_IN_N(coll_n), .CARRIER_SENSE_IN_N(crs_n),
    .TX_DIFF_OE_N(diff_oe_n), .LINK_LED_N(link_n), .TRANSMIT_ACTIVITY_LED_N(tx_led_n), .CORE_RX_ACTIVE(rx_act),
    .CORE_TX_ACTIVE(tx_act), .CORE_LINK_UP(link), .CORE_TX_DATA(tx_data), .CORE_TX_FRAME(tx_frame),
    .CORE_EXTERNAL_MODE(ext_mode), .CORE_RX_DATA(rx_data), .CORE_COLLISION(coll), .CORE_CARRIER(crs));
  always #10 CLK = ~CLK;
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Strap is only taken at reset release, so every mode change needs a reset
  task automatic do_reset(input logic s);
    @(negedge CLK);
    SRST = 1'h1;
    strap = s;
    repeat (8) @(negedge CLK);
    SRST = 1'h0;
    repeat (6) @(negedge CLK);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge CLK);
  endtask
  initial
  begin
    repeat (100000) @(posedge CLK);
    fails++;
    final_report();
  end
  initial
  begin
    {CLK, SRST, strap, rx_act, tx_act, link, coll_n, crs_n} = 8'hFF;
    {tx_data, tx_frame, rx_run, tx_run, rx_bit} = 5'h00;
    fails = 0;
    tests_run = 0;
    foreach (rows[i])
    begin
      do_reset(rows[i].strap);
      {rx_act, tx_act, link} = rows[i].core;
      // Row field holds the active-low pin levels themselves
      {coll_n, crs_n} = rows[i].cs;
      settle(6);
      chk({ext_mode, pad_oe_n, diff_oe_n, coll, crs}, rows[i].em);
      if (rows[i].strap)
        chk(5'({rx_led_n, link_n, tx_led_n}), 5'(rows[i].el));
    end
    rx_run = 1'h1;
    rx_bit = 1'h1;
    settle(20);
    chk(5'(rx_data), 5'h01);
    rx_bit = 1'h0;
    settle(20);
    chk(5'(rx_data), 5'h00);
    tx_run = 1'h1;
    {tx_frame, tx_data} = 2'h3;
    settle(20);
    chk(5'({tx_led_n, link_n}), 5'h01);
    tx_data = 1'h0;
    settle(20);
    chk(5'({tx_led_n, link_n}), 5'h00);
    tx_frame = 1'h0;
    strap = 1'h1;
    settle(20);
    chk(5'({tx_led_n, ext_mode}), 5'h03);
    rx_bit = 1'h1;
    {rx_act, tx_act, link} = 3'h0;
    tx_frame = 1'h1;
    do_reset(1'h1);
    settle(20);
    chk(5'({rx_data, tx_led_n, link_n}), 5'h03);
    rx_act = 1'h1;
    settle(2);
    chk(5'({rx_led_n, pad_oe_n}), 5'h00);
    SRST = 1'h1;
    settle(2);
    chk(5'({rx_led_n, pad_oe_n, ext_mode}), 5'h06);
    final_report();
  end
endmodule
`default_nettype wire
